// File: hw/tsc_pkg.sv
package tsc_pkg;

    // ----------------------------------------------------------------
    // sample carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic signed [11:0] iPart;
        logic signed [11:0] qPart;
    } tsc_iq_sample_t;

    localparam int SAMPLE_W = 12;
    localparam int FIFO_DEPTH = 16;

    // ----------------------------------------------------------------
    // rates and latency, in system sample clock cycles
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int MCLK_DIV = 4;
    localparam int IQ_DIV = 4;
    localparam int LAT_BYPASS_CYC = 119;
    localparam int FILT_EXTRA_CYC = 2;
    localparam int SETTLE_MAX_CYC = 176;
    localparam int HOP_FILT_MAX_CYC = 234;
    localparam int HOP_BYP_MAX_CYC = 232;
    // pop, scale and sum stages stand ahead of the delay line
    localparam int PIPE_FRONT_CYC = 3;
    localparam int DLY_LEN = LAT_BYPASS_CYC - PIPE_FRONT_CYC;
    localparam int FIR_TAPS = 5;
    localparam int DLY_TOT = DLY_LEN + FIR_TAPS - 1;
    localparam logic [7:0] HOP_BYP_CYC = 8'(LAT_BYPASS_CYC);
    localparam logic [7:0] HOP_FILT_CYC =
        8'(LAT_BYPASS_CYC + FILT_EXTRA_CYC);

    // ----------------------------------------------------------------
    // gains: 181/256 is about -3 dB; taps sum to 54/64, about -1.5 dB
    // ----------------------------------------------------------------
    localparam logic signed [8:0] SCALE_NUM = 9'sh0b5;
    localparam int SCALE_SHIFT = 8;
    localparam logic signed [7:0] FIR_C0 = 8'sh01;
    localparam logic signed [7:0] FIR_C1 = 8'shfb;
    localparam logic signed [7:0] FIR_C2 = 8'sh3e;
    localparam int FIR_SHIFT = 6;
    localparam logic signed [11:0] SAT_MAX = 12'sh7ff;
    localparam logic signed [11:0] SAT_MIN = 12'sh800;

    // ----------------------------------------------------------------
    // pin synchroniser layout
    // ----------------------------------------------------------------
    localparam int PIN_W = 4;
    localparam int PIN_FILT = 2;
    localparam int PIN_TONE = 3;
    localparam logic [PIN_W-1:0] PIN_RST = 4'h0;

endpackage

// File: hw/tsc_fifo.sv
`timescale 1ns/1ns
module tsc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // fill side
    input wire logic [WIDTH-1:0] wrData,
    input wire logic wrValid,
    output logic wrReady,
    // drain side
    output logic [WIDTH-1:0] rdData,
    output logic rdValid,
    input wire logic rdReady
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [CW-1:0] count_q, count_d;
    logic notFull_q, notFull_d;
    logic push, pop;

    always_comb
    begin
        push = wrValid && notFull_q;
        pop = rdReady && (count_q != '0);
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        if (push)
            wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
        if (pop)
            rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
        count_d = count_q + CW'(push) - CW'(pop);
        notFull_d = (count_d != CW'(DEPTH));
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            notFull_q <= 1'b0;
        end
        else
        begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            notFull_q <= notFull_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr_q] <= wrData;
    end

    assign wrReady = notFull_q;
    assign rdData = mem[rdPtr_q];
    assign rdValid = (count_q != '0);

endmodule // tsc_fifo

// File: hw/tsc_sinc_backend.sv
`timescale 1ns/1ns
module tsc_sinc_backend (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // modulated samples from upstream
    input wire tsc_pkg::tsc_iq_sample_t inSample,
    input wire logic inValid,
    output logic inReady,
    // DAC side
    input wire logic drainReady,
    output logic signed [11:0] dacWord,
    output logic filterActive,
    // asynchronous mode pins
    input wire logic [1:0] profileSel,
    input wire logic droopCompEnable,
    input wire logic toneMode,
    // profile and rate strobes to upstream
    output logic [1:0] activeProfile,
    output logic hopDone,
    output logic mclkTick,
    output logic iqTick
);
    import tsc_pkg::*;

    function automatic logic signed [11:0] sat12(
        input logic signed [22:0] v);
        if (v > 23'sh0007ff)
            sat12 = SAT_MAX;
        else if (v < 23'sh7ff800)
            sat12 = SAT_MIN;
        else
            sat12 = v[11:0];
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [PIN_W-1:0] pinRaw, s1_q, s2_q, s3_q, pinLvl_q, pinLvl_d;
    assign pinRaw = {toneMode, droopCompEnable, profileSel};

    for (genvar g = 0; g < PIN_W; g++)
    begin : g_sync
        always_comb
        begin
            pinLvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : pinLvl_q[g];
        end
        always_ff @(posedge clk)
        begin
            if (!rst_b)
            begin
                s1_q[g] <= PIN_RST[g];
                s2_q[g] <= PIN_RST[g];
                s3_q[g] <= PIN_RST[g];
                pinLvl_q[g] <= PIN_RST[g];
            end
            else
            begin
                s1_q[g] <= pinRaw[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                pinLvl_q[g] <= pinLvl_d[g];
            end
        end
    end

    // ----------------------------------------------------------------
    // rate strobes
    // ----------------------------------------------------------------
    logic [3:0] divCnt_q, divCnt_d;
    logic mclkTick_q, mclkTick_d, iqTick_q, iqTick_d;

    always_comb
    begin
        divCnt_d = divCnt_q + 4'h1;
        mclkTick_d = (divCnt_q[1:0] == 2'(MCLK_DIV - 1));
        iqTick_d = (divCnt_q == 4'(MCLK_DIV * IQ_DIV - 1));
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            divCnt_q <= 4'h0;
            mclkTick_q <= 1'b0;
            iqTick_q <= 1'b0;
        end
        else
        begin
            divCnt_q <= divCnt_d;
            mclkTick_q <= mclkTick_d;
            iqTick_q <= iqTick_d;
        end
    end

    // ----------------------------------------------------------------
    // input buffer
    // ----------------------------------------------------------------
    tsc_iq_sample_t fifoData, smp;
    logic fifoValid, advance;

    assign advance = drainReady;

    tsc_fifo #(
        .WIDTH($bits(tsc_iq_sample_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .wrData(inSample),
        .wrValid(inValid),
        .wrReady(inReady),
        .rdData(fifoData),
        .rdValid(fifoValid),
        .rdReady(advance)
    );

    // ----------------------------------------------------------------
    // datapath: scale, combine, delay, compensate
    // ----------------------------------------------------------------
    logic signed [11:0] sI_q, sI_d, sQ_q, sQ_d, sum_q, sum_d;
    logic signed [11:0] dacWord_q, dacWord_d;
    logic signed [11:0] dly_q [DLY_TOT];
    logic signed [11:0] dly_d [DLY_TOT];
    logic signed [20:0] prodI, prodQ, firP0, firP1;
    logic signed [19:0] firP2;
    logic signed [22:0] firAcc, accSh;
    logic signed [11:0] firSat;
    logic filtSel_q, filtSel_d, passRaw;

    always_comb
    begin
        smp = fifoValid ? fifoData : '0;
        passRaw = pinLvl_q[PIN_TONE] && !filtSel_q;
        prodI = smp.iPart * SCALE_NUM;
        prodQ = smp.qPart * SCALE_NUM;
        sI_d = sI_q;
        sQ_d = sQ_q;
        sum_d = sum_q;
        filtSel_d = filtSel_q;
        dacWord_d = dacWord_q;
        for (int k = 0; k < DLY_TOT; k++)
            dly_d[k] = dly_q[k];
        // symmetric taps share one multiply per pair
        firP0 = (13'(dly_q[DLY_LEN-1]) + 13'(dly_q[DLY_LEN+3])) * FIR_C0;
        firP1 = (13'(dly_q[DLY_LEN]) + 13'(dly_q[DLY_LEN+2])) * FIR_C1;
        firP2 = dly_q[DLY_LEN+1] * FIR_C2;
        firAcc = 23'(firP0) + 23'(firP1) + 23'(firP2);
        accSh = firAcc >>> FIR_SHIFT;
        firSat = sat12(accSh);
        if (advance)
        begin
            if (passRaw)
            begin
                sI_d = smp.iPart;
                sQ_d = smp.qPart;
            end
            else
            begin
                sI_d = prodI[SCALE_SHIFT+11:SCALE_SHIFT];
                sQ_d = prodQ[SCALE_SHIFT+11:SCALE_SHIFT];
            end
            sum_d = sat12(23'(sI_q) - 23'(sQ_q));
            dly_d[0] = sum_q;
            for (int k = 1; k < DLY_TOT; k++)
                dly_d[k] = dly_q[k-1];
            // centre tap trails the newest by two samples
            dacWord_d = filtSel_q ? firSat : dly_q[DLY_LEN-1];
            filtSel_d = pinLvl_q[PIN_FILT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sI_q <= '0;
            sQ_q <= '0;
            sum_q <= '0;
            dacWord_q <= '0;
            filtSel_q <= 1'b0;
            for (int k = 0; k < DLY_TOT; k++)
                dly_q[k] <= '0;
        end
        else
        begin
            sI_q <= sI_d;
            sQ_q <= sQ_d;
            sum_q <= sum_d;
            dacWord_q <= dacWord_d;
            filtSel_q <= filtSel_d;
            for (int k = 0; k < DLY_TOT; k++)
                dly_q[k] <= dly_d[k];
        end
    end

    // ----------------------------------------------------------------
    // profile hop tracking
    // ----------------------------------------------------------------
    logic [1:0] activeProfile_q, activeProfile_d;
    logic [7:0] hopCnt_q, hopCnt_d;
    logic hopDone_q, hopDone_d;

    always_comb
    begin
        activeProfile_d = activeProfile_q;
        hopCnt_d = (hopCnt_q != 8'h00) ? hopCnt_q - 8'h01 : 8'h00;
        hopDone_d = (hopCnt_q == 8'h01);
        if (pinLvl_q[1:0] != activeProfile_q)
        begin
            activeProfile_d = pinLvl_q[1:0];
            // new tone reaches the DAC after one pipeline transit
            hopCnt_d = filtSel_q ? HOP_FILT_CYC : HOP_BYP_CYC;
            hopDone_d = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            activeProfile_q <= 2'h0;
            hopCnt_q <= 8'h00;
            hopDone_q <= 1'b0;
        end
        else
        begin
            activeProfile_q <= activeProfile_d;
            hopCnt_q <= hopCnt_d;
            hopDone_q <= hopDone_d;
        end
    end

    assign dacWord = dacWord_q;
    assign filterActive = filtSel_q;
    assign activeProfile = activeProfile_q;
    assign hopDone = hopDone_q;
    assign mclkTick = mclkTick_q;
    assign iqTick = iqTick_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [7:0] runCnt_q;
    logic filtPrev_q;
    always_ff @(posedge clk)
    begin
        filtPrev_q <= filtSel_q;
        if (!rst_b || !advance || filtSel_q != filtPrev_q)
            runCnt_q <= 8'h00;
        else if (runCnt_q != 8'hff)
            runCnt_q <= runCnt_q + 8'h01;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_mclk_gap;
        !mclkTick_q [*3] ##1 mclkTick_q;
    endsequence

    property p_mclk_period;
        mclkTick_q |=> s_mclk_gap;
    endproperty
    a_mclk_period: assert property (p_mclk_period)
        else $error("master clock strobe not every fourth cycle");

    property p_iq_period;
        iqTick_q |-> ##16 iqTick_q;
    endproperty
    a_iq_period: assert property (p_iq_period)
        else $error("iq strobe not every sixteenth cycle");

    property p_bypass_latency;
        (runCnt_q >= 8'd130 && !filtSel_q) |-> dacWord_q == $past(sum_q, 117);
    endproperty
    a_bypass_latency: assert property (p_bypass_latency)
        else $error("bypass latency is not 119 cycles");

    sequence s_two_steps;
        advance ##1 advance;
    endsequence

    property p_filter_extra;
        s_two_steps |=> dly_q[DLY_LEN+1] == $past(dly_q[DLY_LEN-1], 2);
    endproperty
    a_filter_extra: assert property (p_filter_extra)
        else $error("centre tap not two samples behind bypass tap");

    property p_hop_filt;
        ($changed(activeProfile_q) && filtSel_q) |-> ##[1:230] hopDone_q;
    endproperty
    a_hop_filt: assert property (p_hop_filt)
        else $error("hop with filter took too long");

    property p_hop_byp;
        ($changed(activeProfile_q) && !filtSel_q) |-> ##[1:228] hopDone_q;
    endproperty
    a_hop_byp: assert property (p_hop_byp)
        else $error("hop without filter took too long");

    property p_saturate;
        (advance && filtSel_q && accSh > 23'sh0007ff)
            |=> dacWord_q == SAT_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("filter output wrapped instead of saturating");

    property p_switch_boundary;
        !advance |=> $stable(filtSel_q) && $stable(dacWord_q);
    endproperty
    a_switch_boundary: assert property (p_switch_boundary)
        else $error("filter path switched between samples");

    property p_scale_fs;
        (advance && !passRaw && smp.iPart == SAT_MAX) |=> sI_q == 12'sh5a7;
    endproperty
    a_scale_fs: assert property (p_scale_fs)
        else $error("full-scale I not attenuated by 3 dB");

    property p_tone_fs;
        (advance && passRaw) |=> sI_q == $past(smp.iPart);
    endproperty
    a_tone_fs: assert property (p_tone_fs)
        else $error("tone mode did not pass full scale");

endmodule // tsc_sinc_backend

// File: tb/tsc_src_model.sv
`timescale 1ns/1ns
module tsc_src_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bench control, each word given as msb and lsb halves
    input wire logic srcOn,
    input wire logic altOn,
    input wire logic [23:0] halvesA,
    input wire logic [23:0] halvesB,
    output logic [15:0] acceptCount,
    // stream into the block
    output tsc_pkg::tsc_iq_sample_t inSample,
    output logic inValid,
    input wire logic inReady
);
    import tsc_pkg::*;

    tsc_iq_sample_t wordQ;
    logic phaseQ;
    logic phaseD;
    logic takeNow;

    // i and q each rebuilt from two 6-bit halves
    function automatic tsc_iq_sample_t join_halves(input logic [23:0] h);
        return {h[23:18], h[17:12], h[11:6], h[5:0]};
    endfunction

    assign takeNow = inValid && inReady;
    assign phaseD = phaseQ ^ takeNow;
    // idle lines show the inverse so stale data is never mistaken
    assign inSample = inValid ? wordQ : ~wordQ;

    initial
    begin
        inValid = 1'b0;
        wordQ = '0;
        phaseQ = 1'b0;
        acceptCount = '0;
    end

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            inValid <= 1'b0;
            phaseQ <= 1'b0;
            acceptCount <= '0;
        end
        else
        begin
            phaseQ <= phaseD;
            acceptCount <= acceptCount + 16'(takeNow);
            // offer held until taken
            if (!inValid || takeNow)
            begin
                inValid <= srcOn;
                wordQ <= join_halves((altOn && phaseD) ? halvesB : halvesA);
            end
        end
    end
endmodule // tsc_src_model

// File: tb/tsc_sinc_backend_test.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) compares++; if ((got) !== (ex)) begin \
$display("Error %s expected %0h seen %0h", nm, ex, got); failCount++; end
module tsc_sinc_backend_test;
    import tsc_pkg::*;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic srcOn = 1'b0;
    logic altOn = 1'b0;
    logic [23:0] halvesA = '0;
    logic [23:0] halvesB = '0;
    logic [15:0] acceptCount;
    tsc_iq_sample_t inSample;
    logic inValid;
    logic inReady;
    logic drainReady = 1'b1;
    logic signed [11:0] dacWord;
    logic filterActive;
    logic [1:0] profileSel = 2'h0;
    logic droopCompEnable = 1'b0;
    logic toneMode = 1'b0;
    logic [1:0] activeProfile;
    logic hopDone;
    logic mclkTick;
    logic iqTick;
    int failCount = 0;
    int compares = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    tsc_src_model src (.clk(clk), .rst_b(rst_b), .srcOn(srcOn),
        .altOn(altOn), .halvesA(halvesA), .halvesB(halvesB),
        .acceptCount(acceptCount), .inSample(inSample),
        .inValid(inValid), .inReady(inReady));

    tsc_sinc_backend dut (.clk(clk), .rst_b(rst_b), .inSample(inSample),
        .inValid(inValid), .inReady(inReady), .drainReady(drainReady),
        .dacWord(dacWord), .filterActive(filterActive),
        .profileSel(profileSel), .droopCompEnable(droopCompEnable),
        .toneMode(toneMode), .activeProfile(activeProfile),
        .hopDone(hopDone), .mclkTick(mclkTick), .iqTick(iqTick));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic pick(input int w);
        case (w)
            0: return mclkTick;
            1: return iqTick;
            2: return hopDone;
            3: return filterActive === droopCompEnable;
            4: return activeProfile === profileSel;
            default: return dacWord !== 12'sh000;
        endcase
    endfunction

    task automatic count_until(input int w, output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (pick(w) !== 1'b1 && n < 400);
    endtask

    task automatic feed(input logic [23:0] a, input logic [23:0] b,
                        input logic alt, input int waitCyc);
        halvesA = a;
        halvesB = b;
        altOn = alt;
        srcOn = 1'b1;
        repeat (waitCyc) @(negedge clk);
    endtask

    task automatic final_report();
        $display("Counts: %0d compares, %0d mismatches", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_ticks();
        int n;
        `CHK("dac at reset", 12'sh000, dacWord)
        count_until(0, n);
        count_until(0, n);
        `CHK("master tick gap", MCLK_DIV, n)
        count_until(1, n);
        count_until(1, n);
        `CHK("iq tick gap", MCLK_DIV * IQ_DIV, n)
        $display("test ticks done");
    endtask

    task automatic t_latency();
        int n;
        halvesA = {12'h400, 12'h000};
        srcOn = 1'b1;
        count_until(5, n);
        `CHK("bypass latency", LAT_BYPASS_CYC + 2, n)
        repeat (SETTLE_MAX_CYC) @(negedge clk);
        `CHK("scaled dc", 12'sd724, dacWord)
        srcOn = 1'b0;
        $display("test latency done");
    endtask

    task automatic t_filter();
        int n;
        droopCompEnable = 1'b1;
        count_until(3, n);
        `CHK("filter switch in time", 1'b1, n <= 6)
        feed({12'h400, 12'h000}, '0, 1'b0, SETTLE_MAX_CYC + 4);
        `CHK("filter dc gain", 1'b1, dacWord inside {610, 611})
        feed({12'h7ff, 12'h800}, {12'h800, 12'h7ff}, 1'b1, SETTLE_MAX_CYC);
        repeat (4)
        begin
            @(negedge clk);
            `CHK("filter clips", 1'b1, dacWord inside {12'sh7ff, 12'sh800})
        end
        srcOn = 1'b0;
        altOn = 1'b0;
        $display("test filter done");
    endtask

    task automatic t_hop(input logic filt);
        int n1;
        int n2;
        droopCompEnable = filt;
        repeat (10) @(negedge clk);
        profileSel = profileSel + 2'h1;
        count_until(4, n1);
        count_until(2, n2);
        `CHK("hop to dac", LAT_BYPASS_CYC + (filt ? FILT_EXTRA_CYC : 0), n2)
        `CHK("hop bound", 1'b1, n1 + n2 < (filt ? HOP_FILT_MAX_CYC : HOP_BYP_MAX_CYC))
        @(negedge clk);
        `CHK("hop pulse width", 1'b0, hopDone)
        $display("test hop done");
    endtask

    task automatic t_tone();
        droopCompEnable = 1'b0;
        toneMode = 1'b1;
        repeat (10) @(negedge clk);
        feed({12'h400, 12'h000}, '0, 1'b0, SETTLE_MAX_CYC + 4);
        `CHK("tone full scale", 12'sd1024, dacWord)
        feed({12'h800, 12'h7ff}, '0, 1'b0, SETTLE_MAX_CYC);
        `CHK("tone clips low", 12'sh800, dacWord)
        srcOn = 1'b0;
        toneMode = 1'b0;
        $display("test tone done");
    endtask

    task automatic t_fifo();
        logic [15:0] base;
        repeat (10) @(negedge clk);
        drainReady = 1'b0;
        base = acceptCount;
        feed({12'h100, 12'h000}, '0, 1'b0, 30);
        `CHK("fifo holds", 16'(FIFO_DEPTH), acceptCount - base)
        `CHK("fifo refuses", 1'b0, inReady)
        srcOn = 1'b0;
        drainReady = 1'b1;
        repeat (40) @(negedge clk);
        `CHK("fifo drained", 1'b1, inReady)
        `CHK("pending word taken", 16'(FIFO_DEPTH + 1), acceptCount - base)
        $display("test fifo done");
    endtask

    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            failCount++;
            final_report();
        end
    end

    initial
    begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        t_ticks();
        t_latency();
        t_filter();
        t_hop(1'b0);
        t_hop(1'b1);
        t_tone();
        t_fifo();
        final_report();
    end
endmodule // tsc_sinc_backend_test
